// File: src/epv_defines.svh
`ifndef EPV_DEFINES_SVH
`define EPV_DEFINES_SVH

`define EPV_NUM_EXC      46
`define EPV_NUM_IRQ      30
`define EPV_IRQ_BASE     6'h10
`define EPV_VALID_MASK   46'h33FF_DDFF_D87C

`define EPV_EXC_NMI      6'h02
`define EPV_EXC_HARD     6'h03
`define EPV_EXC_MEM      6'h04
`define EPV_EXC_BUS      6'h05
`define EPV_EXC_USAGE    6'h06
`define EPV_EXC_SVC      6'h0B
`define EPV_EXC_DEBUG    6'h0C
`define EPV_EXC_PENDABLE_SERVICE_REQUEST   6'h0E
`define EPV_EXC_SYSTICK  6'h0F
`define EPV_EXC_LAST     6'h2D

`define EPV_PRIO_NMI     4'h1
`define EPV_PRIO_HARD    4'h2
`define EPV_PRIO_OFS     4'h3
`define EPV_PRIO_IDLE    4'hF
`define EPV_LEVEL_RST    3'h0

`define EPV_BASE_RST     32'h0000_0000
`define EPV_BASE_MIN     32'h0000_0100
`define EPV_BASE_MAX     32'h3FFF_FF00
`define EPV_BASE_LOWMASK 32'h0000_00FF
`define EPV_NUM_RST      6'h00

`endif

// File: src/epv_pkg.sv
`default_nettype none
`include "epv_defines.svh"

package epv_pkg;

	typedef logic [5:0]  epv_num_t;
	typedef logic [3:0]  epv_prio_t;
	typedef logic [2:0]  epv_level_t;
	typedef logic [31:0] epv_addr_t;

	typedef struct packed {
		logic nmi;
		logic hard_fault;
		logic mem_fault;
		logic bus_fault;
		logic usage_fault;
		logic supervisor_call_exception;
		logic debug_monitor;
		logic pendable_service_request;
		logic systick;
	} epv_sys_req_s;

	typedef struct packed {
		logic     handler_active;
		epv_num_t active_num;
		logic     entry_ack;
		epv_num_t entry_num;
	} epv_core_s;

	typedef struct packed {
		logic       wr;
		logic       priv;
		epv_num_t   num;
		epv_level_t level;
	} epv_prio_wr_s;

	typedef struct packed {
		logic      wr;
		logic      priv;
		epv_addr_t base;
	} epv_base_wr_s;

	typedef struct packed {
		logic      valid;
		epv_num_t  num;
		epv_prio_t prio;
		epv_addr_t addr;
	} epv_vector_s;

	typedef struct packed {
		logic [`EPV_NUM_EXC-1:0]            pend;
		logic [`EPV_NUM_EXC-1:0][2:0]       level;
		epv_addr_t                          base;
		epv_vector_s                        win;
	} epv_state_s;

endpackage : epv_pkg

`default_nettype wire

// File: src/epv_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "epv_defines.svh"

module epv_select (
	// candidates
	input  wire logic [`EPV_NUM_EXC-1:0]                  cand,
	input  wire epv_pkg::epv_prio_t [`EPV_NUM_EXC-1:0]    prio,
	// winner
	output var  logic                                     win_valid,
	output var  epv_pkg::epv_num_t                        win_num,
	output var  epv_pkg::epv_prio_t                       win_prio
);

	// scan upward with strict less: on a tie the lower number stays
	always_comb begin
		win_valid = 1'b0;
		win_num   = `EPV_NUM_RST;
		win_prio  = `EPV_PRIO_IDLE;
		for (int i = 0; i < `EPV_NUM_EXC; i++) begin
			if (cand[i] && (!win_valid || prio[i] < win_prio)) begin
				win_valid = 1'b1;
				win_num   = 6'(i);
				win_prio  = prio[i];
			end
		end
	end

endmodule : epv_select

`default_nettype wire

// File: src/epv_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "epv_defines.svh"

module epv_top (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic                  ce,
	// interrupt sources
	input  wire logic [`EPV_NUM_IRQ-1:0] irq_req,
	input  wire epv_pkg::epv_sys_req_s sys_req,
	// configuration
	input  wire epv_pkg::epv_prio_wr_s prio_wr,
	input  wire epv_pkg::epv_base_wr_s base_wr,
	// core side
	input  wire epv_pkg::epv_core_s    core,
	output var  logic                  take_req,
	output var  epv_pkg::epv_num_t     vec_num,
	output var  epv_pkg::epv_addr_t    vec_addr,
	output var  epv_pkg::epv_addr_t    vector_table_base_offset,
	output var  logic [`EPV_NUM_EXC-1:0] pend_out
);

	epv_pkg::epv_state_s                      state_r;
	epv_pkg::epv_state_s                      state_nxt;
	epv_pkg::epv_prio_t [`EPV_NUM_EXC-1:0]    eff_prio;
	logic [`EPV_NUM_EXC-1:0]                  set_vec;
	logic [`EPV_NUM_EXC-1:0]                  clr_vec;
	logic [`EPV_NUM_EXC-1:0]                  valid_mask;
	logic [`EPV_NUM_EXC-1:0]                  prog_mask;
	logic                                     sel_valid;
	epv_pkg::epv_num_t                        sel_num;
	epv_pkg::epv_prio_t                       sel_prio;
	epv_pkg::epv_prio_t                       active_prio;
	logic                                     base_ok;

	assign valid_mask = `EPV_VALID_MASK;

	// per-entry effective priority, offset so -3 maps to zero
	for (genvar i = 0; i < `EPV_NUM_EXC; i++) begin : g_entry
		localparam epv_pkg::epv_num_t NUM = 6'(i);
		if (NUM == `EPV_EXC_NMI) begin : g_nmi
			assign eff_prio[i]  = `EPV_PRIO_NMI;
			assign prog_mask[i] = 1'b0;
		end else if (NUM == `EPV_EXC_HARD) begin : g_hard
			assign eff_prio[i]  = `EPV_PRIO_HARD;
			assign prog_mask[i] = 1'b0;
		end else if (NUM < `EPV_EXC_MEM) begin : g_fixed
			assign eff_prio[i]  = `EPV_PRIO_IDLE;
			assign prog_mask[i] = 1'b0;
		end else begin : g_prog
			// levels are 3 bits, so they always sit below the fixed NMI and hard fault ones
			assign eff_prio[i]  = {1'b0, state_r.level[i]} + `EPV_PRIO_OFS;
			assign prog_mask[i] = valid_mask[i];
		end
	end

	// request lines to exception numbers
	always_comb begin
		set_vec = '0;
		set_vec[`EPV_IRQ_BASE +: `EPV_NUM_IRQ] = irq_req;
		set_vec[`EPV_EXC_NMI]     = sys_req.nmi;
		set_vec[`EPV_EXC_HARD]    = sys_req.hard_fault;
		set_vec[`EPV_EXC_MEM]     = sys_req.mem_fault;
		set_vec[`EPV_EXC_BUS]     = sys_req.bus_fault;
		set_vec[`EPV_EXC_USAGE]   = sys_req.usage_fault;
		set_vec[`EPV_EXC_SVC]     = sys_req.supervisor_call_exception;
		set_vec[`EPV_EXC_DEBUG]   = sys_req.debug_monitor;
		set_vec[`EPV_EXC_PENDABLE_SERVICE_REQUEST]  = sys_req.pendable_service_request;
		set_vec[`EPV_EXC_SYSTICK] = sys_req.systick;
	end

	// the core clears an entry's pending bit when it enters its handler
	always_comb begin
		clr_vec = '0;
		if (core.entry_ack && core.entry_num <= `EPV_EXC_LAST) begin
			clr_vec[core.entry_num] = 1'b1;
		end
	end

	epv_select u_select (
		.cand      (state_r.pend & valid_mask),
		.prio      (eff_prio),
		.win_valid (sel_valid),
		.win_num   (sel_num),
		.win_prio  (sel_prio)
	);

	// misaligned or out-of-range bases are dropped rather than truncated
	assign base_ok = base_wr.wr && base_wr.priv
		&& base_wr.base >= `EPV_BASE_MIN
		&& base_wr.base <= `EPV_BASE_MAX
		&& (base_wr.base & `EPV_BASE_LOWMASK) == `EPV_BASE_RST;

	always_comb begin
		state_nxt = state_r;
		// set wins over clear so an arrival during entry is kept
		state_nxt.pend = ((state_r.pend & ~clr_vec) | set_vec)
			& valid_mask;
		if (prio_wr.wr && prio_wr.priv
			&& prio_wr.num <= `EPV_EXC_LAST) begin
			if (prog_mask[prio_wr.num]) begin
				state_nxt.level[prio_wr.num] = prio_wr.level;
			end
		end
		if (base_ok) begin
			state_nxt.base = base_wr.base;
		end
		state_nxt.win.valid = sel_valid;
		state_nxt.win.num   = sel_num;
		state_nxt.win.prio  = sel_prio;
		// slot 0 holds the stack value, handlers follow by number
		state_nxt.win.addr  = state_r.base
			+ {26'h0, sel_num} * 32'h0000_0004;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r.pend      <= '0;
			state_r.level     <= {`EPV_NUM_EXC{`EPV_LEVEL_RST}};
			state_r.base      <= `EPV_BASE_RST;
			state_r.win.valid <= 1'b0;
			state_r.win.num   <= `EPV_NUM_RST;
			state_r.win.prio  <= `EPV_PRIO_IDLE;
			state_r.win.addr  <= `EPV_BASE_RST;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	// priority of the running handler; thread mode counts as idle
	always_comb begin
		active_prio = `EPV_PRIO_IDLE;
		if (core.handler_active && core.active_num <= `EPV_EXC_LAST) begin
			active_prio = eff_prio[core.active_num];
		end
	end

	// strict less: an equal level waits in pending instead
	assign take_req = state_r.win.valid
		&& (!core.handler_active
		|| state_r.win.prio < active_prio);

	assign vec_num  = state_r.win.num;
	assign vec_addr = state_r.win.addr;
	assign vector_table_base_offset = state_r.base;
	assign pend_out = state_r.pend;

endmodule : epv_top

`default_nettype wire

// File: test/epv_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module epv_core_model #(
	parameter int DLY = 3
) (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	// block side
	input  wire logic               en_ack,
	input  wire logic               take_req,
	input  wire epv_pkg::epv_num_t  vec_num,
	output var epv_pkg::epv_core_s  core
);
	int cnt;
	epv_pkg::epv_addr_t pc;
	// enters only while asked, a few cycles late like a real fetch
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			core <= '0;
			cnt  <= 0;
			pc   <= '0;
		end else begin
			core.entry_ack <= 1'b0;
			if (en_ack && take_req && !core.entry_ack) begin
				if (cnt == DLY) begin
					core <= '{1'b1, vec_num, 1'b1, vec_num};
					// handler words as software lays them out, bit 0 set
					pc   <= {20'h0, vec_num, 6'h01};
					cnt  <= 0;
				end else begin
					cnt <= cnt + 1;
				end
			end else begin
				cnt <= 0;
			end
		end
	end
endmodule : epv_core_model
`default_nettype wire

// File: test/epv_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "epv_defines.svh"
module epv_top_sva (
	// clock and inputs
	input wire logic                        clk_sys,
	input wire logic                        rstn,
	input wire logic                        ce,
	input wire logic [`EPV_NUM_IRQ-1:0]     irq_req,
	input wire epv_pkg::epv_sys_req_s       sys_req,
	input wire epv_pkg::epv_prio_wr_s       prio_wr,
	input wire epv_pkg::epv_base_wr_s       base_wr,
	input wire epv_pkg::epv_core_s          core,
	// outputs
	input wire logic                        take_req,
	input wire epv_pkg::epv_num_t           vec_num,
	input wire epv_pkg::epv_addr_t          vec_addr,
	input wire epv_pkg::epv_addr_t          vector_table_base_offset,
	input wire logic [`EPV_NUM_EXC-1:0]     pend_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	addr_form_a: assert property (
		$stable(vector_table_base_offset) |-> vec_addr
			== vector_table_base_offset + {vec_num, 2'b00})
		else $error("bad vec_addr");
	rsvd_pend_a: assert property (
		(pend_out & ~`EPV_VALID_MASK) == '0)
		else $error("reserved pending");
	irq_map_a: assert property (
		ce && irq_req[0] |=> pend_out[16])
		else $error("irq0 not pending");
	base_rst_a: assert property (
		$rose(rstn) |-> vector_table_base_offset == 32'h0000_0000)
		else $error("base not zero");
	base_range_a: assert property (
		vector_table_base_offset == '0
		|| (vector_table_base_offset >= `EPV_BASE_MIN
		&& vector_table_base_offset <= `EPV_BASE_MAX
		&& (vector_table_base_offset & `EPV_BASE_LOWMASK) == '0))
		else $error("base out of range");
	nmi_wins_a: assert property (
		ce && sys_req.nmi ##1 ce |=> vec_num == `EPV_EXC_NMI)
		else $error("nmi lost");
	equal_hold_a: assert property (
		core.handler_active && core.active_num == vec_num |-> !take_req)
		else $error("equal preempt");
	idle_take_a: assert property (
		(ce && pend_out != '0) ##1 !core.handler_active |-> take_req)
		else $error("idle not taken");
endmodule : epv_top_sva
bind epv_top epv_top_sva u_sva (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
	.irq_req(irq_req), .sys_req(sys_req), .prio_wr(prio_wr),
	.base_wr(base_wr), .core(core), .take_req(take_req), .vec_num(vec_num),
	.vec_addr(vec_addr), .vector_table_base_offset(vector_table_base_offset),
	.pend_out(pend_out));
`default_nettype wire

// File: test/epv_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module epv_top_tb_top;
	typedef struct {int k; logic [45:0] e;} epv_note_s;
	logic                  clk_sys = 1'b0;
	logic                  rstn = 1'b0;
	logic                  en_ack = 1'b0;
	logic                  ce = 1'b1;
	logic [29:0]           irq_req = '0;
	epv_pkg::epv_sys_req_s sys_req = '0;
	epv_pkg::epv_prio_wr_s prio_wr = '0;
	epv_pkg::epv_base_wr_s base_wr = '0;
	epv_pkg::epv_core_s    core;
	logic                  take_req;
	epv_pkg::epv_num_t     vec_num;
	epv_pkg::epv_addr_t    vec_addr, vt_base, base_exp;
	logic [45:0]           pend_out;
	epv_note_s             q[$];
	epv_note_s             n;
	int err_total = 0, n_checks = 0, cyc = 0, seed = 37;
	string nm[5] = '{"vec_num", "vec_addr", "base", "pend_out", "take_req"};
	always #10 clk_sys = ~clk_sys;
	epv_top DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .irq_req(irq_req),
		.sys_req(sys_req), .prio_wr(prio_wr), .base_wr(base_wr), .core(core),
		.take_req(take_req), .vec_num(vec_num), .vec_addr(vec_addr),
		.vector_table_base_offset(vt_base), .pend_out(pend_out));
	epv_core_model u_core (.clk_sys(clk_sys), .rstn(rstn), .en_ack(en_ack),
		.take_req(take_req), .vec_num(vec_num), .core(core));
	task automatic check(input int k, input logic [45:0] s, e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm[k], e, s);
		end
	endtask : check
	// settled values, half a cycle after the launching edge
	always @(negedge clk_sys) begin
		while (q.size() > 0) begin
			n = q.pop_front();
			case (n.k)
				0: check(0, 46'(vec_num), n.e);
				1: check(1, 46'(vec_addr), n.e);
				2: check(2, 46'(vt_base), n.e);
				3: check(3, pend_out, n.e);
				default: check(4, 46'(take_req), n.e);
			endcase
		end
	end
	task automatic note(input int k, input logic [45:0] e);
		q.push_back('{k, e});
	endtask : note
	task automatic tick(input int c);
		repeat (c) @(posedge clk_sys);
	endtask : tick
	task automatic do_reset;
		@(posedge clk_sys);
		rstn <= 1'b0;
		tick(16);
		rstn <= 1'b1;
	endtask : do_reset
	task automatic pulse(input logic [29:0] m, input logic [8:0] s);
		@(posedge clk_sys);
		irq_req <= m;
		sys_req <= s;
		@(posedge clk_sys);
		irq_req <= '0;
		sys_req <= '0;
		tick(2);
	endtask : pulse
	task automatic prio(input logic [5:0] x, input logic [2:0] l,
		input logic p = 1'b1);
		@(posedge clk_sys);
		prio_wr <= '{1'b1, p, x, l};
		@(posedge clk_sys);
		prio_wr <= '0;
		tick(2);
	endtask : prio
	task automatic base(input logic p, input epv_pkg::epv_addr_t b);
		@(posedge clk_sys);
		base_wr <= '{1'b1, p, b};
		@(posedge clk_sys);
		base_wr <= '0;
		tick(2);
	endtask : base
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		do_reset();
		note(2, 46'h0);
		pulse(30'h3, 9'h000);
		note(0, 46'h10);
		note(1, 46'h40);
		prio(6'h10, 3'h5);
		note(0, 46'h11);
		pulse(30'h0, 9'h080);
		note(0, 46'h3);
		pulse(30'h0, 9'h100);
		note(0, 46'h2);
		pulse(30'h200, 9'h000);
		note(3, 46'h3_000C);
		// frozen: a request seen while ce is low must not pend
		ce <= 1'b0;
		pulse(30'h8, 9'h000);
		note(3, 46'h3_000C);
		ce <= 1'b1;
		// aligned, above the floor, below the ceiling
		base_exp = {2'b00, 22'($random(seed)) | 22'h1, 8'h00};
		base(1'b1, base_exp);
		note(2, base_exp);
		note(1, base_exp + 32'h8);
		base(1'b1, base_exp + 32'h80);
		base(1'b0, 32'h0000_0200);
		base(1'b1, 32'h4000_0000);
		base(1'b1, 32'h0000_0000);
		note(2, base_exp);
		do_reset();
		note(2, 46'h0);
		en_ack <= 1'b1;
		prio(6'h11, 3'h3);
		prio(6'h10, 3'h3);
		// unprivileged write must leave 17 at level 3
		prio(6'h11, 3'h0, 1'b0);
		pulse(30'h2, 9'h000);
		for (int i = 0; i < 20 && core.handler_active !== 1'b1; i++) begin
			tick(1);
		end
		pulse(30'h1, 9'h000);
		note(4, 46'h0);
		note(3, 46'h1_0000);
		pulse(30'h4, 9'h000);
		note(4, 46'h1);
		note(0, 46'h12);
		tick(2);
		conclude();
	end
endmodule : epv_top_tb_top
`default_nettype wire
